// ==== hw/handler_sort_consts.svh ====
// timing counts, class and point counts and result codes for the handler sort interface
`ifndef HANDLER_SORT_CONSTS_SVH
`define HANDLER_SORT_CONSTS_SVH

`define CLOCK_MHZ 200
`define TRIG_MIN_WIDTH_NS 1000
`define TRIG_DELAY_US 200
`define TRIG_DELAY_CYCLES (`TRIG_DELAY_US * `CLOCK_MHZ)
`define COMPARE_TIME_US 1000
`define COMPARE_CYCLES (`COMPARE_TIME_US * `CLOCK_MHZ)
`define DISP_MEAS_US 8000
`define DISP_CLASS_NUM_US 5000
`define DISP_CLASS_COUNT_US 500
`define DISP_MEAS_CYCLES (`DISP_MEAS_US * `CLOCK_MHZ)
`define DISP_CLASS_NUM_CYCLES (`DISP_CLASS_NUM_US * `CLOCK_MHZ)
`define DISP_CLASS_COUNT_CYCLES (`DISP_CLASS_COUNT_US * `CLOCK_MHZ)
`define CLASS_COUNT 9
`define SWEEP_POINTS 10
`define RESULT_REJECT 4'hA
`define RESULT_AUX 4'hB

`endif

// ==== hw/handler_sort_pkg.sv ====
// shared types for the handler sort interface
package handler_sort_pkg;
    typedef enum logic [1:0] {
        PAGE_MEASUREMENT,
        PAGE_CLASS_NUMBER,
        PAGE_CLASS_COUNT
    } display_page_e;

    typedef enum logic [1:0] {
        MODE_CLASS_COMPARE,
        MODE_SWEEP_SEQUENTIAL,
        MODE_SWEEP_PER_POINT
    } compare_mode_e;
endpackage

// ==== hw/cycle_timer.sv ====
// down counter that pulses when a loaded count has elapsed
`timescale 1ns/10ps
module cycle_timer (
    input wire logic clock,
    input wire logic reset,
    input wire logic load,
    input wire logic [23:0] count,
    output logic done
);
    logic [23:0] remain_reg;
    logic running_reg;

    always_ff @(posedge clock) begin
        if (reset) begin
            remain_reg <= 24'h000000;
            running_reg <= 1'b0;
        end else if (load) begin
            remain_reg <= count;
            running_reg <= 1'b1;
        end else if (running_reg) begin
            if (remain_reg <= 24'h000001) begin
                running_reg <= 1'b0;
            end
            remain_reg <= remain_reg - 24'h000001;
        end
    end

    // no load term: load is made from done
    assign done = running_reg && (remain_reg <= 24'h000001);
endmodule

// ==== hw/trigger_edge_detect.sv ====
// rising-edge detector for the external trigger, gated by the trigger source
`timescale 1ns/10ps
module trigger_edge_detect (
    input wire logic clock,
    input wire logic reset,
    input wire logic externalTriggerInput,
    input wire logic externalSource,
    output logic triggerPulse
);
    logic lastLevel_reg;

    // trigger is taken as synchronous; only the level history is kept
    always_ff @(posedge clock) begin
        if (reset) begin
            lastLevel_reg <= 1'b0;
        end else begin
            lastLevel_reg <= externalTriggerInput;
        end
    end

    assign triggerPulse = externalSource && externalTriggerInput
        && !lastLevel_reg;
endmodule

// ==== hw/handler_sort_interface.sv ====
// handler port: trigger, key lock, sort outputs and done strobes
//
// What this block does
// - every handler output except busy is active low; asserted means driven low.
// - with external trigger source, each rising trigger edge while idle starts a test.
// - panel-lock input or handler use masks all front-panel keys.
// - class mode reports each part on one class, reject or aux line.
// - above-high flag in class mode when primary value exceeds the upper class limit.
// - below-low flag in class mode when primary value falls under the lower limit.
// - secondary-reject flag when the result lies outside valid range.
// - alarm output asserted while the measurement circuit is interrupted.
// - analog-done strobe as soon as the analog test portion completes.
// - comparison outputs not valid between analog-done and measure-done.
// - measure-done only once data and comparison results are valid.
// - trigger to measurement start is 200 us up to display plus 200 us.
// - limit comparison completes in about one millisecond.
// - display time is 8 ms, 5 ms or 0.5 ms by active page.
// - in sweep, class lines plus reject show per-point in or out.
// - in sweep, auxiliary line gives the overall pass or fail verdict.
// - in sweep, per-point outputs are driven after the whole sweep.
// - sequential sweep: analog-done after the final point's analog test.
// - sequential sweep: measure-done after all tasks and results valid.
// - per-point sweep: analog-done after the first point's analog test, held until the next trigger.
// - per-point sweep: measure-done once every point has been tested.
`timescale 1ns/10ps
`include "handler_sort_consts.svh"
module handler_sort_interface
    import handler_sort_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    // trigger and lock inputs from the handler
    input wire logic externalTriggerInput,
    input wire logic panelLockInput,
    input wire logic externalSource,
    input wire logic [3:0] frontPanelKeys,
    output logic [3:0] acceptedKeys,
    // configuration
    input wire compare_mode_e compareMode,
    input wire display_page_e displayPage,
    input wire logic [3:0] sweepPointCount,
    input wire logic handlerEnable,
    // measurement engine handshake
    output logic measureStart,
    input wire logic analogDone,
    input wire logic [15:0] primaryValue,
    input wire logic resultInRange,
    input wire logic circuitOpen,
    // limit table
    input wire logic [15:0] classUpper [`CLASS_COUNT],
    input wire logic [15:0] classLower [`CLASS_COUNT],
    input wire logic [15:0] auxUpper,
    input wire logic [15:0] auxLower,
    input wire logic [15:0] pointUpper,
    input wire logic [15:0] pointLower,
    // active-low handler outputs, plus the active-high busy flag
    output logic [8:0] sortClassOutputs_n,
    output logic rejectOutput_n,
    output logic auxOutput_n,
    output logic primaryAboveHighFlag_n,
    output logic primaryBelowLowFlag_n,
    output logic secondaryRejectFlag_n,
    output logic alarmOutput_n,
    output logic analogDoneStrobe_n,
    output logic measurementDoneStrobe_n,
    output logic busy
);
    // ==========================================================
    // types and helpers
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DELAY,
        ST_MEASURE,
        ST_COMPARE,
        ST_DISPLAY
    } phase_e;

    function automatic logic inLimits(input logic [15:0] v,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
        inLimits = (v >= lo) && (v <= hi);
    endfunction

    function automatic logic [23:0] displayCycles(input display_page_e p);
        case (p)
            PAGE_MEASUREMENT: displayCycles = 24'(`DISP_MEAS_CYCLES);
            PAGE_CLASS_NUMBER: displayCycles = 24'(`DISP_CLASS_NUM_CYCLES);
            PAGE_CLASS_COUNT: displayCycles = 24'(`DISP_CLASS_COUNT_CYCLES);
            default: displayCycles = 24'(`DISP_MEAS_CYCLES);
        endcase
    endfunction

    phase_e phase_reg;
    logic [3:0] pointIndex_reg;
    logic [9:0] pointFail_reg;
    logic [8:0] classOut_reg;
    logic rejectOut_reg;
    logic auxOut_reg;
    logic aboveHigh_reg;
    logic belowLow_reg;
    logic secReject_reg;
    logic resultsValid_reg;
    logic analogStrobe_reg;
    logic doneStrobe_reg;
    logic alarm_reg;
    logic timerLoad;
    logic [23:0] timerCount;
    logic timerDone;
    logic triggerPulse;
    logic acceptTrigger;
    logic sweepMode;
    logic lastPoint;
    logic [3:0] lastIndex;
    logic [8:0] classHit;
    logic [3:0] firstClass;

    // ==========================================================
    // trigger and timing submodules
    trigger_edge_detect edgeDetect (
        .clock(clock),
        .reset(reset),
        .externalTriggerInput(externalTriggerInput),
        .externalSource(externalSource),
        .triggerPulse(triggerPulse)
    );

    cycle_timer phaseTimer (
        .clock(clock),
        .reset(reset),
        .load(timerLoad),
        .count(timerCount),
        .done(timerDone)
    );

    // back-to-back triggers are fine once the previous test is done
    assign acceptTrigger = triggerPulse && (phase_reg == ST_IDLE);
    assign sweepMode = (compareMode != MODE_CLASS_COMPARE);
    assign lastIndex = (sweepPointCount == 4'h0) ? 4'h0
        : sweepPointCount - 4'h1;
    assign lastPoint = !sweepMode || (pointIndex_reg >= lastIndex);
    assign busy = (phase_reg != ST_IDLE);

    // ==========================================================
    // key lock
    always_ff @(posedge clock) begin
        if (reset) begin
            acceptedKeys <= 4'h0;
        end else if (panelLockInput || handlerEnable) begin
            acceptedKeys <= 4'h0;
        end else begin
            acceptedKeys <= frontPanelKeys;
        end
    end

    // ==========================================================
    // phase timer loading
    always_comb begin
        timerLoad = 1'b0;
        timerCount = 24'h000001;
        if (acceptTrigger) begin
            timerLoad = 1'b1;
            timerCount = 24'(`TRIG_DELAY_CYCLES);
        end else if (phase_reg == ST_MEASURE && analogDone && lastPoint) begin
            timerLoad = 1'b1;
            timerCount = 24'(`COMPARE_CYCLES);
        end else if (phase_reg == ST_MEASURE && analogDone) begin
            timerLoad = 1'b1;
            timerCount = 24'(`TRIG_DELAY_CYCLES);
        end else if (phase_reg == ST_COMPARE && timerDone) begin
            timerLoad = 1'b1;
            timerCount = displayCycles(displayPage);
        end
    end

    // ==========================================================
    // sequencing: delay, measure each point, compare, display
    always_ff @(posedge clock) begin
        if (reset) begin
            phase_reg <= ST_IDLE;
            measureStart <= 1'b0;
            pointIndex_reg <= 4'h0;
        end else begin
            measureStart <= 1'b0;
            case (phase_reg)
                ST_IDLE: begin
                    if (acceptTrigger) begin
                        phase_reg <= ST_DELAY;
                        pointIndex_reg <= 4'h0;
                    end
                end
                ST_DELAY: begin
                    if (timerDone) begin
                        measureStart <= 1'b1;
                        phase_reg <= ST_MEASURE;
                    end
                end
                ST_MEASURE: begin
                    if (analogDone) begin
                        if (lastPoint) begin
                            phase_reg <= ST_COMPARE;
                        end else begin
                            pointIndex_reg <= pointIndex_reg + 4'h1;
                            phase_reg <= ST_DELAY;
                        end
                    end
                end
                ST_COMPARE: begin
                    if (timerDone) begin
                        phase_reg <= ST_DISPLAY;
                    end
                end
                ST_DISPLAY: begin
                    if (timerDone) begin
                        phase_reg <= ST_IDLE;
                    end
                end
                default: phase_reg <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // per-point sweep verdicts gathered as each point completes
    always_ff @(posedge clock) begin
        if (reset) begin
            pointFail_reg <= 10'h000;
        end else if (acceptTrigger) begin
            pointFail_reg <= 10'h000;
        end else if (phase_reg == ST_MEASURE && analogDone && sweepMode
                     && pointIndex_reg < 4'(`SWEEP_POINTS)) begin
            pointFail_reg[pointIndex_reg] <=
                !inLimits(primaryValue, pointLower, pointUpper);
        end
    end

    // ==========================================================
    // class sorting: first class whose window holds the value
    always_comb begin
        firstClass = `RESULT_REJECT;
        for (int i = `CLASS_COUNT - 1; i >= 0; i--) begin
            classHit[i] = inLimits(primaryValue, classLower[i], classUpper[i]);
            if (classHit[i]) begin
                firstClass = 4'(i);
            end
        end
    end

    // ==========================================================
    // result outputs: cleared at trigger, loaded at end of compare
    always_ff @(posedge clock) begin
        if (reset || acceptTrigger) begin
            classOut_reg <= 9'h000;
            rejectOut_reg <= 1'b0;
            auxOut_reg <= 1'b0;
            aboveHigh_reg <= 1'b0;
            belowLow_reg <= 1'b0;
            secReject_reg <= 1'b0;
            resultsValid_reg <= 1'b0;
        end else if (phase_reg == ST_COMPARE && timerDone) begin
            resultsValid_reg <= 1'b1;
            secReject_reg <= !resultInRange;
            if (sweepMode) begin
                classOut_reg <= pointFail_reg[8:0];
                rejectOut_reg <= pointFail_reg[9];
                auxOut_reg <= |pointFail_reg;
                aboveHigh_reg <= 1'b0;
                belowLow_reg <= 1'b0;
            end else begin
                // limits are the outer edges of classes one and nine
                aboveHigh_reg <=
                    primaryValue > classUpper[`CLASS_COUNT - 1];
                belowLow_reg <= primaryValue < classLower[0];
                if (!resultInRange) begin
                    rejectOut_reg <= 1'b1;
                end else if (firstClass != `RESULT_REJECT) begin
                    classOut_reg <= 9'h001 << firstClass;
                end else if (inLimits(primaryValue, auxLower, auxUpper)) begin
                    auxOut_reg <= 1'b1;
                end else begin
                    rejectOut_reg <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // handshake strobes
    always_ff @(posedge clock) begin
        if (reset || acceptTrigger) begin
            analogStrobe_reg <= 1'b0;
        end else if (phase_reg == ST_MEASURE && analogDone) begin
            case (compareMode)
                MODE_SWEEP_PER_POINT: analogStrobe_reg <= 1'b1;
                MODE_SWEEP_SEQUENTIAL:
                    analogStrobe_reg <= lastPoint;
                default: analogStrobe_reg <= 1'b1;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset || acceptTrigger) begin
            doneStrobe_reg <= 1'b0;
        end else if (phase_reg == ST_COMPARE && timerDone) begin
            // one cycle after results load would lag; assert with them
            doneStrobe_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            alarm_reg <= 1'b0;
        end else begin
            alarm_reg <= circuitOpen;
        end
    end

    // ==========================================================
    // active-low drive; results hidden until they are valid
    always_comb begin
        sortClassOutputs_n = ~(classOut_reg & {9{resultsValid_reg}});
        rejectOutput_n = ~(rejectOut_reg & resultsValid_reg);
        auxOutput_n = ~(auxOut_reg & resultsValid_reg);
        primaryAboveHighFlag_n = ~(aboveHigh_reg & resultsValid_reg);
        primaryBelowLowFlag_n = ~(belowLow_reg & resultsValid_reg);
        secondaryRejectFlag_n = ~(secReject_reg & resultsValid_reg);
        alarmOutput_n = ~alarm_reg;
        analogDoneStrobe_n = ~analogStrobe_reg;
        measurementDoneStrobe_n = ~doneStrobe_reg;
    end
endmodule

// ==== testbench/handler_sort_interface_props.sv ====
// checker for the handler sort interface port behaviour
`timescale 1ns/10ps
`include "handler_sort_consts.svh"
module handler_sort_interface_props
    import handler_sort_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic panelLockInput,
    input wire logic handlerEnable,
    input wire logic [3:0] frontPanelKeys,
    input wire logic [3:0] acceptedKeys,
    input wire compare_mode_e compareMode,
    input wire logic analogDone,
    input wire logic measureStart,
    input wire logic [15:0] primaryValue,
    input wire logic [15:0] classUpper [`CLASS_COUNT],
    input wire logic [8:0] sortClassOutputs_n,
    input wire logic rejectOutput_n,
    input wire logic auxOutput_n,
    input wire logic primaryAboveHighFlag_n,
    input wire logic analogDoneStrobe_n,
    input wire logic measurementDoneStrobe_n,
    input wire logic busy
);
    int delayCount_reg;
    int compareCount_reg;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // ====================================================================
    // helper counters
    // the delays are far beyond what a repetition can unroll
    always_ff @(posedge clock) begin
        if (reset || !busy) begin
            delayCount_reg <= 0;
        end else begin
            delayCount_reg <= delayCount_reg + 1;
        end
    end
    always_ff @(posedge clock) begin
        if (reset || analogDoneStrobe_n) begin
            compareCount_reg <= 0;
        end else if (measurementDoneStrobe_n) begin
            compareCount_reg <= compareCount_reg + 1;
        end
    end
    // ====================================================================
    // properties
    property p_reset_idle;
        @(posedge clock) disable iff (1'b0) reset |=> (&sortClassOutputs_n)
            && rejectOutput_n && measurementDoneStrobe_n && !busy;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("outputs not released after reset");
    property p_keys_locked;
        !$past(reset) && $past(panelLockInput || handlerEnable)
            |-> acceptedKeys == 4'h0;
    endproperty
    a_keys_locked: assert property (p_keys_locked)
        else $error("keys passed while locked");
    property p_keys_pass;
        !$past(reset) && !$past(panelLockInput || handlerEnable)
            |-> acceptedKeys == $past(frontPanelKeys);
    endproperty
    a_keys_pass: assert property (p_keys_pass)
        else $error("keys lost while unlocked");
    property p_start_delay;
        measureStart && compareMode == MODE_CLASS_COMPARE
            |-> delayCount_reg >= `TRIG_DELAY_CYCLES - 1
            && delayCount_reg <= `TRIG_DELAY_CYCLES + `DISP_MEAS_CYCLES;
    endproperty
    a_start_delay: assert property (p_start_delay)
        else $error("trigger to start delay out of bounds");
    property p_trig_clears;
        $rose(busy) |-> analogDoneStrobe_n && measurementDoneStrobe_n;
    endproperty
    a_trig_clears: assert property (p_trig_clears)
        else $error("strobes not cleared by new trigger");
    property p_analog_strobe;
        analogDone && busy && compareMode != MODE_SWEEP_SEQUENTIAL
            |=> !analogDoneStrobe_n;
    endproperty
    a_analog_strobe: assert property (p_analog_strobe)
        else $error("analog done strobe missing");
    property p_no_early;
        !analogDoneStrobe_n && measurementDoneStrobe_n
            |-> (&sortClassOutputs_n) && rejectOutput_n && auxOutput_n;
    endproperty
    a_no_early: assert property (p_no_early)
        else $error("results shown before measurement done");
    property p_one_class;
        $fell(measurementDoneStrobe_n) && compareMode == MODE_CLASS_COMPARE
            |-> $countones(~{sortClassOutputs_n, rejectOutput_n,
            auxOutput_n}) == 1;
    endproperty
    a_one_class: assert property (p_one_class)
        else $error("not exactly one sort line asserted");
    property p_high_flag;
        $fell(measurementDoneStrobe_n) && compareMode == MODE_CLASS_COMPARE
            |-> primaryAboveHighFlag_n
            == !(primaryValue > classUpper[`CLASS_COUNT - 1]);
    endproperty
    a_high_flag: assert property (p_high_flag)
        else $error("above high flag wrong");
    property p_compare_time;
        $fell(measurementDoneStrobe_n)
            |-> compareCount_reg >= `COMPARE_CYCLES - 2;
    endproperty
    a_compare_time: assert property (p_compare_time)
        else $error("measurement done too soon");
    property p_done_stands;
        $fell(measurementDoneStrobe_n) |=> !measurementDoneStrobe_n [*8];
    endproperty
    a_done_stands: assert property (p_done_stands)
        else $error("measurement done strobe dropped");
    c_start: cover property (measureStart);
    c_analog: cover property ($fell(analogDoneStrobe_n));
    c_done: cover property ($fell(measurementDoneStrobe_n));
endmodule

// ==== testbench/handler_model.sv ====
// handler machine model: issues trigger pulses of legal width
`timescale 1ns/10ps
module handler_model #(
    parameter int HOLD_CYCLES = 200
) (
    input wire logic clock,
    input wire logic fire,
    output logic externalTriggerInput
);
    int hold = 0;
    // ====================================================================
    // one microsecond at 200 MHz; a new pulse may follow right away
    always @(negedge clock) begin
        if (hold > 0) begin
            hold <= hold - 1;
        end else if (fire) begin
            hold <= HOLD_CYCLES;
        end
    end
    assign externalTriggerInput = (hold > 0);
endmodule

// ==== testbench/test_handler_sort_interface.sv ====
// testbench for the handler sort interface
`timescale 1ns/10ps
`include "handler_sort_consts.svh"
module test_handler_sort_interface import handler_sort_pkg::*;;
    typedef struct packed {
        logic lock;
        logic en;
        logic [3:0] keys;
        logic [3:0] exp;
    } key_row_s;
    key_row_s rows [4] = '{'{1'h0, 1'h0, 4'h5, 4'h5},
        '{1'h1, 1'h0, 4'hA, 4'h0}, '{1'h0, 1'h1, 4'hF, 4'h0},
        '{1'h0, 1'h0, 4'hC, 4'hC}};
    logic clock, reset, fire, externalTriggerInput, panelLockInput;
    logic externalSource, handlerEnable, measureStart, analogDone;
    logic resultInRange, circuitOpen, rejectOutput_n, auxOutput_n, busy;
    logic primaryAboveHighFlag_n, primaryBelowLowFlag_n, alarmOutput_n;
    logic secondaryRejectFlag_n, analogDoneStrobe_n;
    logic measurementDoneStrobe_n;
    logic [3:0] frontPanelKeys, acceptedKeys, sweepPointCount;
    logic [8:0] sortClassOutputs_n, expSort;
    logic [15:0] primaryValue, auxUpper, auxLower, pointUpper, pointLower;
    logic [15:0] classUpper [`CLASS_COUNT];
    logic [15:0] classLower [`CLASS_COUNT];
    compare_mode_e compareMode;
    display_page_e displayPage;
    int mismatches = 0;
    int n_tests = 0;
    int clockCount = 0;
    int n;
    handler_model i_handler_model (.clock(clock), .fire(fire),
        .externalTriggerInput(externalTriggerInput));
    handler_sort_interface i_handler_sort_interface (.clock(clock),
        .reset(reset), .externalTriggerInput(externalTriggerInput),
        .panelLockInput(panelLockInput), .externalSource(externalSource),
        .frontPanelKeys(frontPanelKeys), .acceptedKeys(acceptedKeys),
        .compareMode(compareMode), .displayPage(displayPage),
        .sweepPointCount(sweepPointCount), .handlerEnable(handlerEnable),
        .measureStart(measureStart), .analogDone(analogDone),
        .primaryValue(primaryValue), .resultInRange(resultInRange),
        .circuitOpen(circuitOpen), .classUpper(classUpper),
        .classLower(classLower), .auxUpper(auxUpper), .auxLower(auxLower),
        .pointUpper(pointUpper), .pointLower(pointLower),
        .sortClassOutputs_n(sortClassOutputs_n),
        .rejectOutput_n(rejectOutput_n), .auxOutput_n(auxOutput_n),
        .primaryAboveHighFlag_n(primaryAboveHighFlag_n),
        .primaryBelowLowFlag_n(primaryBelowLowFlag_n),
        .secondaryRejectFlag_n(secondaryRejectFlag_n),
        .alarmOutput_n(alarmOutput_n),
        .analogDoneStrobe_n(analogDoneStrobe_n),
        .measurementDoneStrobe_n(measurementDoneStrobe_n), .busy(busy));
    // ====================================================================
    // reporting
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ====================================================================
    // clock and hang guard
    initial begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end
    // two measurements need about 481000 cycles
    always @(posedge clock) begin
        clockCount++;
        if (clockCount == 520000) begin
            mismatches++;
            close_out;
        end
    end
    // ====================================================================
    // main sequence
    initial begin
        reset = 1'h1;
        fire = 1'h0;
        panelLockInput = 1'h0;
        handlerEnable = 1'h0;
        externalSource = 1'h0;
        frontPanelKeys = 4'h0;
        compareMode = MODE_CLASS_COMPARE;
        displayPage = PAGE_CLASS_COUNT;
        sweepPointCount = 4'h1;
        analogDone = 1'h0;
        primaryValue = 16'h015E;
        resultInRange = 1'h1;
        circuitOpen = 1'h0;
        {auxUpper, auxLower, pointUpper, pointLower} = 64'h0;
        for (int i = 0; i < `CLASS_COUNT; i++) begin
            classLower[i] = 16'(i * 100 + 100);
            classUpper[i] = 16'(i * 100 + 199);
        end
        expSort = ~(9'h001 << 2);
        repeat (20) @(negedge clock);
        reset = 1'h0;
        check("idle class", sortClassOutputs_n, 9'h1FF);
        check("idle done", measurementDoneStrobe_n, 1'h1);
        check("idle busy", busy, 1'h0);
        foreach (rows[i]) begin
            panelLockInput = rows[i].lock;
            handlerEnable = rows[i].en;
            frontPanelKeys = rows[i].keys;
            @(negedge clock);
            check("keys", acceptedKeys, rows[i].exp);
        end
        fire <= 1'h1;
        @(negedge clock);
        fire <= 1'h0;
        repeat (300) @(negedge clock);
        check("source off", busy, 1'h0);
        externalSource = 1'h1;
        fire <= 1'h1;
        @(negedge clock);
        fire <= 1'h0;
        n = 0;
        // a second trigger in mid-wait must not restart the delay
        while (measureStart !== 1'h1 && n < 50000) begin
            @(negedge clock);
            n++;
            fire <= (n == 1000);
        end
        check("delay", n >= `TRIG_DELAY_CYCLES &&
            n <= `TRIG_DELAY_CYCLES + 2, 1'h1);
        repeat (5) @(negedge clock);
        analogDone = 1'h1;
        @(negedge clock);
        analogDone = 1'h0;
        check("analog", analogDoneStrobe_n, 1'h0);
        check("early done", measurementDoneStrobe_n, 1'h1);
        check("early class", sortClassOutputs_n, 9'h1FF);
        n = 0;
        while (measurementDoneStrobe_n !== 1'h0 && n < 250000) begin
            @(negedge clock);
            n++;
        end
        check("compare", n >= `COMPARE_CYCLES - 8 &&
            n <= `COMPARE_CYCLES + 8, 1'h1);
        check("class", sortClassOutputs_n, expSort);
        check("reject", rejectOutput_n, 1'h1);
        check("aux", auxOutput_n, 1'h1);
        check("above", primaryAboveHighFlag_n, 1'h1);
        check("below", primaryBelowLowFlag_n, 1'h1);
        check("range", secondaryRejectFlag_n, 1'h1);
        check("alarm", alarmOutput_n, 1'h1);
        circuitOpen = 1'h1;
        @(negedge clock);
        check("alarm on", alarmOutput_n, 1'h0);
        reset = 1'h1;
        @(negedge clock);
        reset = 1'h0;
        check("rst done", measurementDoneStrobe_n, 1'h1);
        check("rst busy", busy, 1'h0);
        compareMode = MODE_SWEEP_SEQUENTIAL;
        fire <= 1'h1;
        @(negedge clock);
        fire <= 1'h0;
        while (measureStart !== 1'h1) begin
            @(negedge clock);
        end
        analogDone = 1'h1;
        @(negedge clock);
        analogDone = 1'h0;
        while (measurementDoneStrobe_n !== 1'h0) begin
            @(negedge clock);
        end
        check("points", sortClassOutputs_n, 9'h1FE);
        check("verdict", auxOutput_n, 1'h0);
        close_out;
    end
endmodule
bind handler_sort_interface handler_sort_interface_props i_props (
    .clock(clock), .reset(reset), .panelLockInput(panelLockInput),
    .handlerEnable(handlerEnable), .frontPanelKeys(frontPanelKeys),
    .acceptedKeys(acceptedKeys), .compareMode(compareMode),
    .analogDone(analogDone), .measureStart(measureStart),
    .primaryValue(primaryValue), .classUpper(classUpper),
    .sortClassOutputs_n(sortClassOutputs_n),
    .rejectOutput_n(rejectOutput_n), .auxOutput_n(auxOutput_n),
    .primaryAboveHighFlag_n(primaryAboveHighFlag_n),
    .analogDoneStrobe_n(analogDoneStrobe_n),
    .measurementDoneStrobe_n(measurementDoneStrobe_n), .busy(busy));
